// ### rtl/sync_two_flop.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and control.
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // Asynchronous level in, synchronised level out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // The first stage is read only by the second stage.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### rtl/uart_ctl_pkg.sv
package uart_ctl_pkg;
    // Register byte addresses within the slave window.
    localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
    localparam logic [7:0] OFS_INT_ID     = 8'h08;
    localparam logic [7:0] OFS_HS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_LINE_STAT  = 8'h14;
    localparam logic [7:0] OFS_HS_STATUS  = 8'h18;
    localparam logic [7:0] OFS_SCRATCH    = 8'h1C;
    localparam int ADDR_W = 8;

    // Enable register bit positions.
    localparam int IE_RXDATA = 0;
    localparam int IE_HOLD   = 1;
    localparam int IE_LINE   = 2;
    localparam int IE_MODEM  = 3;
    localparam int IE_W      = 4;

    // Handshake control bit positions.
    localparam int HC_TERM_READY = 0;
    localparam int HC_REQ_SEND   = 1;
    localparam int HC_USER1      = 2;
    localparam int HC_USER2      = 3;
    localparam int HC_LOOP       = 4;
    localparam int HC_W          = 5;

    // Modem nibble order: clear-to-send, set-ready, ring, carrier.
    localparam int MD_CTS = 0;
    localparam int MD_DSR = 1;
    localparam int MD_RI  = 2;
    localparam int MD_DCD = 3;

    // Source codes in identification bits 2:1, bit 0 set when idle.
    localparam logic [1:0] ID_LINE  = 2'b11;
    localparam logic [1:0] ID_RXDAT = 2'b10;
    localparam logic [1:0] ID_HOLD  = 2'b01;
    localparam logic [1:0] ID_MODEM = 2'b00;
    localparam logic [2:0] ID_NONE  = 3'b001;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic       RST_HOLD_EMPTY = 1'b1;

    // Sample timing: ticks per bit and mark time needed after a break.
    localparam int TICK_SHIFT = 4;
    localparam int MARK_TICKS = 8;
    localparam int SPACE_W    = 9;
    localparam int MARK_W     = 4;

    // Bus encodings.
    localparam logic       HRESP_OKAY = 1'b0;
    localparam int         HTRANS_ACT = 1;
endpackage

// ### rtl/uart_status_irq_modem_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module uart_status_irq_modem_ctrl (
    // Clock, reset and clock enable.
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         ce,
    // Register bus slave.
    input  wire logic                         hsel,
    input  wire logic [uart_ctl_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic [31:0]                       hrdata,
    output logic                              hresp,
    // Receive shift logic.
    input  wire logic                         rxCharDone,
    input  wire logic                         rxParityBad,
    input  wire logic                         rxStopBad,
    input  wire logic                         rxBufRead,
    input  wire logic                         sampleTick,
    input  wire logic [3:0]                   frameBits,
    output logic                              rxLine,
    output logic                              rxEnable,
    output logic                              rxResync,
    // Transmit shift logic.
    input  wire logic                         holdWrite,
    input  wire logic                         holdToShift,
    input  wire logic                         shiftBusy,
    input  wire logic                         txShiftOut,
    // Serial pins.
    input  wire logic                         serialInput,
    output logic                              serialOutput,
    // Modem pins, all active low.
    input  wire logic                         ctsN,
    input  wire logic                         dsrN,
    input  wire logic                         riN,
    input  wire logic                         dcdN,
    output logic                              dtrN,
    output logic                              rtsN,
    output logic                              out1N,
    output logic                              out2N,
    // Interrupt to the CPU.
    output logic                              interruptRequestOut
);
    import uart_ctl_pkg::*;

    typedef struct packed {
        logic [IE_W-1:0]   intEnable;
        logic [HC_W-1:0]   hsControl;
        logic [7:0]        scratch;
        logic              receiveReadyFlag;
        logic              overrunFlag;
        logic              parityFaultFlag;
        logic              framingErrorFlag;
        logic              breakDetectFlag;
        logic              holdingEmptyFlag;
        logic              holdIrq;
        logic [3:0]        modemChange;
        logic [3:0]        modemPrev;
        logic [SPACE_W-1:0] spaceCnt;
        logic              breakHold;
        logic [MARK_W-1:0] markCnt;
        logic              resync;
        logic              wrPend;
        logic [ADDR_W-1:0] wrAddr;
        logic [31:0]       rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic [3:0]         pinSync;
    logic               serialSync;
    logic [3:0]         modemNow;
    logic               loop;
    logic               transmitterIdle;
    logic [7:0]         lineStatus;
    logic [7:0]         hsStatus;
    logic [2:0]         idNow;
    logic               sel;
    logic               lsRead;
    logic               msRead;
    logic               idRead;
    logic [SPACE_W-1:0] frameTicks;

    // Priority encoder of pending enabled sources into the id byte.
    function automatic logic [2:0] id_f(input logic ls, input logic rd,
                                        input logic th, input logic ms);
        logic [2:0] r;
        r = ID_NONE;
        if (ls) begin
            r = {ID_LINE, 1'b0};
        end else if (rd) begin
            r = {ID_RXDAT, 1'b0};
        end else if (th) begin
            r = {ID_HOLD, 1'b0};
        end else if (ms) begin
            r = {ID_MODEM, 1'b0};
        end
        return r;
    endfunction

    // Pins from outside the clock domain pass two flops first.
    sync_two_flop #(.W(4), .RST_VAL(4'hF)) u_modem_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .d       ({dcdN, riN, dsrN, ctsN}),
        .q       (pinSync)
    );
    sync_two_flop #(.W(1), .RST_VAL(1'b1)) u_serial_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .d       (serialInput),
        .q       (serialSync)
    );

    // Loopback steering of line, pins and modem inputs.
    assign loop         = st_r.hsControl[HC_LOOP];
    assign rxLine       = loop ? txShiftOut : serialSync;
    assign serialOutput = loop | txShiftOut;
    assign dtrN  = loop | ~st_r.hsControl[HC_TERM_READY];
    assign rtsN  = loop | ~st_r.hsControl[HC_REQ_SEND];
    assign out1N = loop | ~st_r.hsControl[HC_USER1];
    assign out2N = loop | ~st_r.hsControl[HC_USER2];
    assign modemNow = loop ? {st_r.hsControl[HC_USER2],
                              st_r.hsControl[HC_USER1],
                              st_r.hsControl[HC_TERM_READY],
                              st_r.hsControl[HC_REQ_SEND]}
                           : ~pinSync;

    // Status views; line status bit 7 and unused bits are tied to zero.
    assign transmitterIdle = st_r.holdingEmptyFlag & ~shiftBusy;
    assign lineStatus = {1'b0, transmitterIdle, st_r.holdingEmptyFlag,
                         st_r.breakDetectFlag, st_r.framingErrorFlag,
                         st_r.parityFaultFlag, st_r.overrunFlag,
                         st_r.receiveReadyFlag};
    assign hsStatus   = {modemNow, st_r.modemChange};

    // Disabled sources never reach the id byte or the pin.
    assign idNow = id_f(st_r.intEnable[IE_LINE] &
                        (st_r.overrunFlag | st_r.parityFaultFlag |
                         st_r.framingErrorFlag | st_r.breakDetectFlag),
                        st_r.intEnable[IE_RXDATA] & st_r.receiveReadyFlag,
                        st_r.intEnable[IE_HOLD] & st_r.holdIrq,
                        st_r.intEnable[IE_MODEM] & (|st_r.modemChange));
    assign interruptRequestOut = st_r.hsControl[HC_USER2] & ~idNow[0];

    // Bus address phase; stalling while frozen keeps side effects exact.
    assign hreadyout = ce;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = st_r.rdata;
    assign rxEnable  = ~st_r.breakHold;
    assign rxResync  = st_r.resync;
    assign sel    = hsel & hready & htrans[HTRANS_ACT];
    assign lsRead = sel & ~hwrite & (haddr == OFS_LINE_STAT);
    assign msRead = sel & ~hwrite & (haddr == OFS_HS_STATUS);
    assign idRead = sel & ~hwrite & (haddr == OFS_INT_ID);
    assign frameTicks = SPACE_W'({frameBits, {TICK_SHIFT{1'b0}}});

    // Next-state logic: sets always win over clears in the same cycle.
    always_comb begin
        st_nxt = st_r;
        st_nxt.resync = 1'b0;
        // Read side effects and snapshot of the read data.
        if (sel & ~hwrite) begin
            unique case (haddr)
                OFS_INT_ENABLE: st_nxt.rdata = {28'h0000000, st_r.intEnable};
                OFS_INT_ID:     st_nxt.rdata = {29'h00000000, idNow};
                OFS_HS_CONTROL: st_nxt.rdata = {27'h0000000, st_r.hsControl};
                OFS_LINE_STAT:  st_nxt.rdata = {24'h000000, lineStatus};
                OFS_HS_STATUS:  st_nxt.rdata = {24'h000000, hsStatus};
                OFS_SCRATCH:    st_nxt.rdata = {24'h000000, st_r.scratch};
                default:        st_nxt.rdata = 32'h00000000;
            endcase
        end
        if (lsRead) begin
            st_nxt.overrunFlag      = 1'b0;
            st_nxt.parityFaultFlag  = 1'b0;
            st_nxt.framingErrorFlag = 1'b0;
            st_nxt.breakDetectFlag  = 1'b0;
        end
        if (msRead) begin
            st_nxt.modemChange = 4'h0;
        end
        if (idRead && idNow == {ID_HOLD, 1'b0}) begin
            st_nxt.holdIrq = 1'b0;
        end
        // Write data phase uses the address latched a cycle earlier.
        st_nxt.wrPend = sel & hwrite;
        st_nxt.wrAddr = haddr;
        if (st_r.wrPend) begin
            unique case (st_r.wrAddr)
                OFS_INT_ENABLE: st_nxt.intEnable = hwdata[IE_W-1:0];
                OFS_HS_CONTROL: st_nxt.hsControl = hwdata[HC_W-1:0];
                OFS_SCRATCH:    st_nxt.scratch = hwdata[7:0];
                default:        st_nxt.scratch = st_nxt.scratch;
            endcase
        end
        // Receive buffer events.
        if (rxBufRead) begin
            st_nxt.receiveReadyFlag = 1'b0;
        end
        if (rxCharDone) begin
            st_nxt.receiveReadyFlag = 1'b1;
            if (st_r.receiveReadyFlag & ~rxBufRead) begin
                st_nxt.overrunFlag = 1'b1;
            end
            if (rxParityBad) begin
                st_nxt.parityFaultFlag = 1'b1;
            end
        end
        if (rxStopBad) begin
            st_nxt.framingErrorFlag = 1'b1;
            st_nxt.resync = ~rxLine;
        end
        // Transmit holding register tracking.
        if (holdWrite) begin
            st_nxt.holdingEmptyFlag = 1'b0;
            st_nxt.holdIrq = 1'b0;
        end
        if (holdToShift) begin
            st_nxt.holdingEmptyFlag = 1'b1;
            st_nxt.holdIrq = 1'b1;
        end
        // Break timing: count spacing ticks, then wait for enough mark.
        if (rxLine) begin
            st_nxt.spaceCnt = '0;
        end else if (sampleTick && st_r.spaceCnt <= frameTicks) begin
            st_nxt.spaceCnt = st_r.spaceCnt + SPACE_W'(1);
            if (st_r.spaceCnt == frameTicks) begin
                st_nxt.breakDetectFlag = 1'b1;
                st_nxt.breakHold = 1'b1;
            end
        end
        if (!rxLine) begin
            st_nxt.markCnt = '0;
        end else if (sampleTick && st_r.breakHold) begin
            st_nxt.markCnt = st_r.markCnt + MARK_W'(1);
            if (st_r.markCnt == MARK_W'(MARK_TICKS - 1)) begin
                st_nxt.breakHold = 1'b0;
            end
        end
        // Modem change detection on the effective inputs.
        st_nxt.modemPrev = modemNow;
        st_nxt.modemChange[MD_CTS] = st_nxt.modemChange[MD_CTS] |
            (modemNow[MD_CTS] ^ st_r.modemPrev[MD_CTS]);
        st_nxt.modemChange[MD_DSR] = st_nxt.modemChange[MD_DSR] |
            (modemNow[MD_DSR] ^ st_r.modemPrev[MD_DSR]);
        st_nxt.modemChange[MD_DCD] = st_nxt.modemChange[MD_DCD] |
            (modemNow[MD_DCD] ^ st_r.modemPrev[MD_DCD]);
        st_nxt.modemChange[MD_RI] = st_nxt.modemChange[MD_RI] |
            (st_r.modemPrev[MD_RI] & ~modemNow[MD_RI]);
    end

    // State register; a low enable freezes everything.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.holdingEmptyFlag <= RST_HOLD_EMPTY;
            st_r.scratch <= RST_BYTE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_fe_set;
        ce && rxStopBad |=> st_r.framingErrorFlag;
    endproperty
    a_fe_set: assert property (p_fe_set)
        else $error("framing flag not set");

    property p_resync;
        ce && rxStopBad && !rxLine |=> rxResync ##1 !rxResync;
    endproperty
    a_resync: assert property (p_resync)
        else $error("resync pulse missing");

    property p_break;
        ce && sampleTick && !rxLine && st_r.spaceCnt == frameTicks
            |=> st_r.breakDetectFlag && !rxEnable;
    endproperty
    a_break: assert property (p_break)
        else $error("break not detected");

    property p_ls_clear;
        ce && lsRead && !rxStopBad |=> !st_r.framingErrorFlag;
    endproperty
    a_ls_clear: assert property (p_ls_clear)
        else $error("status read left framing flag");

    property p_hold_empty;
        ce && holdWrite && !holdToShift |=> !st_r.holdingEmptyFlag;
    endproperty
    a_hold_empty: assert property (p_hold_empty)
        else $error("holding empty flag not cleared");

    property p_idle;
        shiftBusy |-> !lineStatus[6] && !lineStatus[7];
    endproperty
    a_idle: assert property (p_idle)
        else $error("transmitter idle while shifting");

    property p_rank;
        st_r.intEnable[IE_LINE] && st_r.overrunFlag
            |-> idNow == {ID_LINE, 1'b0};
    endproperty
    a_rank: assert property (p_rank)
        else $error("line status not top priority");

    property p_id_snap;
        ce && idRead |=> hrdata == {29'h00000000, $past(idNow)};
    endproperty
    a_id_snap: assert property (p_id_snap)
        else $error("id snapshot wrong");

    property p_irq;
        interruptRequestOut |-> st_r.hsControl[HC_USER2] && !idNow[0];
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without enable");

    property p_loop;
        loop |-> serialOutput && dtrN && rtsN && out1N && out2N;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loopback pins not idle");

    property p_ring;
        ce && st_r.modemPrev[MD_RI] && !modemNow[MD_RI]
            |=> st_r.modemChange[MD_RI];
    endproperty
    a_ring: assert property (p_ring)
        else $error("ring edge missed");

    c_break: cover property (st_r.breakDetectFlag ##[1:50] rxEnable);
    c_overrun: cover property (ce && rxCharDone && st_r.receiveReadyFlag);
    c_loop_ms: cover property (loop ##1 st_r.modemChange != 4'h0);
endmodule
`default_nettype wire

// ### verif/modem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Lines the data set asserts: clear, ready, ring, carrier.
    input  wire logic [3:0] lines,
    // Handshake pins towards the channel, active low.
    output logic            ctsN,
    output logic            dsrN,
    output logic            riN,
    output logic            dcdN
);
    // Pins move just after an edge; reset leaves every line inactive.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {dcdN, riN, dsrN, ctsN} <= 4'hF;
        end else begin
            {dcdN, riN, dsrN, ctsN} <= ~lines;
        end
    end
endmodule
`default_nettype wire

// ### verif/test_uart_status_irq_modem_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_uart_status_irq_modem_ctrl;
    import uart_ctl_pkg::*;
    logic        mclk, sysRst, ce, hsel, hwrite, shiftBusy, txShiftOut;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata;
    logic        rxCharDone, rxParityBad, rxStopBad, rxBufRead, sampleTick;
    logic        holdWrite, holdToShift, serialInput;
    logic [3:0]  lines;
    wire         hreadyout, rxLine, rxEnable, rxResync, serialOutput, irq;
    wire         dtrN, rtsN, out1N, out2N, ctsN, dsrN, riN, dcdN, hresp;
    wire  [31:0] hrdata;
    // Bench model of the register state.
    logic [5:0]  lsr;
    logic [3:0]  interrupt_enable_mask, dl, effOld;
    logic [4:0]  handshake_control;
    logic [7:0]  scr;
    logic        thi;
    int          error_cnt, checks;

    uart_status_irq_modem_ctrl dut (.mclk, .sys_rst(sysRst), .ce, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .rxCharDone, .rxParityBad, .rxStopBad,
        .rxBufRead, .sampleTick, .frameBits(4'hA), .rxLine, .rxEnable,
        .rxResync, .holdWrite, .holdToShift, .shiftBusy, .txShiftOut,
        .serialInput, .serialOutput, .ctsN, .dsrN, .riN, .dcdN, .dtrN, .rtsN,
        .out1N, .out2N, .interruptRequestOut(irq));
    modem_partner mdm (.mclk, .sys_rst(sysRst), .lines, .ctsN, .dsrN, .riN,
        .dcdN);

    // Free-running 100 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // In loopback the control bits stand in for the modem lines.
    function automatic logic [3:0] effMs();
        return handshake_control[4] ? {handshake_control[3], handshake_control[2], handshake_control[0], handshake_control[1]} : lines;
    endfunction

    // Highest enabled pending source, ranked as the channel ranks them.
    function automatic logic [7:0] expId();
        if (interrupt_enable_mask[2] && lsr[4:1] != 4'h0) return 8'h06;
        if (interrupt_enable_mask[0] && lsr[0]) return 8'h04;
        if (interrupt_enable_mask[1] && thi) return 8'h02;
        if (interrupt_enable_mask[3] && dl != 4'h0) return 8'h00;
        return 8'h01;
    endfunction

    // Ring only counts its trailing edge; the others count any change.
    task automatic trackMs();
        logic [3:0] n;
        n = effMs();
        dl |= {n[3] ^ effOld[3], effOld[2] & ~n[2], n[1:0] ^ effOld[1:0]};
        effOld = n;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bounded wait for hready; running out ends the run as a failure.
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, a};
        waitReady();
        {htrans, hwdata} <= {2'b00, d};
        waitReady();
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        case (a)
            OFS_INT_ENABLE: interrupt_enable_mask = d[3:0];
            OFS_HS_CONTROL: handshake_control = d[4:0];
            OFS_SCRATCH:    scr = d[7:0];
            default:        ;
        endcase
        trackMs();
    endtask

    // Expectation is fixed at the address edge, then read side effects.
    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        logic [7:0]  id;
        id = expId();
        case (a)
            OFS_LINE_STAT:  e = {25'h0, lsr[5] & !shiftBusy, lsr};
            OFS_INT_ID:     e = {24'h0, id};
            OFS_INT_ENABLE: e = {28'h0, interrupt_enable_mask};
            OFS_HS_CONTROL: e = {27'h0, handshake_control};
            OFS_HS_STATUS:  e = {24'h0, effMs(), dl};
            OFS_SCRATCH:    e = {24'h0, scr};
            default:        e = 32'h0;
        endcase
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), hrdata, e);
        chk("resp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
        if (a == OFS_LINE_STAT) lsr[4:1] = 4'h0;
        if (a == OFS_HS_STATUS) dl = 4'h0;
        if (a == OFS_INT_ID && id == 8'h02) thi = 1'b0;
        id = expId();
        chk("irq", {31'h0, irq}, {31'h0, handshake_control[3] & !id[0]});
    endtask

    // Bits: shift move, holding write, buffer read, stop bad, char done.
    task automatic strobe(input logic [4:0] s);
        {holdToShift, holdWrite, rxBufRead, rxStopBad, rxCharDone} <= s;
        @(posedge mclk);
        {holdToShift, holdWrite, rxBufRead, rxStopBad, rxCharDone} <= 5'h0;
        #1;
        // A buffer read in the same cycle as a new character avoids overrun.
        if (s[2]) lsr[0] = 1'b0;
        if (s[0]) lsr[2:0] = {lsr[2] | rxParityBad, lsr[1] | lsr[0], 1'b1};
        if (s[1]) lsr[3] = 1'b1;
        if (s[3]) {lsr[5], thi} = 2'b00;
        if (s[4]) {lsr[5], thi} = 2'b11;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            sampleTick <= 1'b1;
            @(posedge mclk);
            sampleTick <= 1'b0;
            @(posedge mclk);
        end
        #1;
    endtask

    // Main sequence: reset, then one scenario after another.
    initial begin
        {ce, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 44'h0};
        {rxCharDone, rxParityBad, rxStopBad, rxBufRead, sampleTick} = 5'h0;
        {holdWrite, holdToShift, shiftBusy, txShiftOut} = 4'h0;
        {serialInput, lines, lsr} = {1'b1, 4'h0, 6'h20};
        {interrupt_enable_mask, dl, effOld, handshake_control, thi, scr} = 26'h0;
        {error_cnt, checks} = {32'h0, 32'h0};
        sysRst = 1'b1;
        repeat (8) @(posedge mclk);
        sysRst <= 1'b0;
        void'($urandom(14));
        idle(1);
        chk("pins", {27'h0, dtrN, rtsN, out1N, out2N, rxEnable},
            32'h1F);
        // Every word slot from the enable register up to the scratch store.
        for (int i = 1; i < 8; i++) begin
            rd(8'(4 * i));
        end
        wr(OFS_SCRATCH, $urandom());
        rd(OFS_SCRATCH);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20);
        strobe(5'h08);
        rd(OFS_LINE_STAT);
        shiftBusy <= 1'b1;
        strobe(5'h10);
        rd(OFS_LINE_STAT);
        shiftBusy <= 1'b0;
        wr(OFS_INT_ENABLE, 32'hFF);
        rd(OFS_INT_ENABLE);
        wr(OFS_HS_CONTROL, 32'hEF);
        chk("outs", {28'h0, dtrN, rtsN, out1N, out2N}, 32'h0);
        rd(OFS_HS_CONTROL);
        rd(OFS_INT_ID);
        rd(OFS_INT_ID);
        lines <= 4'hF;
        idle(5);
        trackMs();
        lines <= 4'hB;
        idle(5);
        trackMs();
        rxParityBad <= 1'b1;
        strobe(5'h03);
        strobe(5'h01);
        rxParityBad <= 1'b0;
        strobe(5'h18);
        rd(OFS_INT_ID);
        rd(OFS_LINE_STAT);
        rd(OFS_INT_ID);
        strobe(5'h04);
        rd(OFS_INT_ID);
        rd(OFS_INT_ID);
        rd(OFS_HS_STATUS);
        rd(OFS_INT_ID);
        wr(OFS_INT_ENABLE, 32'h0);
        lines <= 4'h3;
        idle(5);
        trackMs();
        rd(OFS_INT_ID);
        rd(OFS_HS_STATUS);
        wr(OFS_HS_CONTROL, 32'h0);
        wr(OFS_INT_ENABLE, 32'h0F);
        strobe(5'h01);
        rd(OFS_INT_ID);
        strobe(5'h04);
        wr(OFS_HS_CONTROL, 32'h08);
        serialInput <= 1'b0;
        idle(4);
        strobe(5'h02);
        chk("resync", {31'h0, rxResync}, 32'h1);
        ticks(164);
        chk("rx on", {31'h0, rxEnable}, 32'h0);
        lsr[4] = 1'b1;
        rd(OFS_INT_ID);
        rd(OFS_LINE_STAT);
        serialInput <= 1'b1;
        idle(4);
        ticks(7);
        chk("rx on", {31'h0, rxEnable}, 32'h0);
        ticks(1);
        chk("rx on", {31'h0, rxEnable}, 32'h1);
        wr(OFS_HS_CONTROL, 32'h1F);
        txShiftOut <= 1'b0;
        idle(4);
        chk("loop", {26'h0, serialOutput, rxLine, dtrN, rtsN, out1N, out2N},
            32'h2F);
        rd(OFS_HS_STATUS);
        wr(OFS_HS_CONTROL, 32'h0);
        idle(4);
        rd(OFS_HS_STATUS);
        tally_and_finish();
    end
endmodule
`default_nettype wire
